// ===== logic/xcvr_reset_map.svh
// Register offsets, field positions, reset values and widths for the transceiver reset block
`ifndef XCVR_RESET_MAP_SVH
`define XCVR_RESET_MAP_SVH
`define XR_CTRL_OFF 12'h000
`define XR_STATUS_OFF 12'h004
`define XR_CFG_OFF 12'h008
`define XR_CTRL_RST 3'h0
`define XR_CTRL_PD_BIT 0
`define XR_CTRL_RXPCS_BIT 1
`define XR_CTRL_TXPCS_BIT 2
`define XR_CFG_BITS 18
`define XR_RESP_OKAY 2'h0
`define XR_RESP_SLVERR 2'h2
`endif

// ===== logic/xcvr_reset_pkg.sv
// Types shared by the transceiver reset and PLL reprogramming block
package xcvr_reset_pkg;
  // One reset line for each block of the channel
  typedef struct packed {
    logic bist_ver;
    logic rx_xaui_sm;
    logic rx_phase_fifo;
    logic rx_byte_order;
    logic rx_byte_deser;
    logic rx_dec;
    logic rx_rate_fifo;
    logic rx_deskew;
    logic rx_aligner;
    logic rx_deser;
    logic rx_cdr;
    logic rx_buf;
    logic tx_xaui_sm;
    logic tx_buf;
    logic tx_ser;
  } blk_rst_s;
  // Fabric-side reset and scan pins, raw and after synchronisation
  typedef struct packed {
    logic rx_pcs;
    logic rx_ana;
    logic tx_pcs;
    logic pll;
    logic pd;
    logic scan_clk;
    logic scan_gate;
    logic scan_din;
    logic cfg_update;
  } pins_s;
endpackage : xcvr_reset_pkg

// ===== logic/xcvr_reset_pll_reconfig_port.sv
// Transceiver channel reset fan-out, PLL serial reprogramming port and AXI4-Lite registers
// What this block does
// - Receive PCS reset clears all receive digital blocks
// - Transmit PCS reset clears serializer, transmit XAUI only
// - Power-down reaches every block; analog reset clears CDR
// - Scan clock gate enables the scan clock
// - PLL raises done when reprogramming finishes
// - PLL shifts current configuration out serially
`include "xcvr_reset_map.svh"
module xcvr_reset_pll_reconfig_port (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Fabric reset pins, all asynchronous to aclk
  input wire logic rx_pcs_reset,
  input wire logic rx_analog_reset,
  input wire logic tx_pcs_reset,
  input wire logic pll_reset,
  input wire logic chan_powerdown,
  // PLL serial reprogramming port from the controller
  input wire logic scan_clk,
  input wire logic scan_clk_gate,
  input wire logic scan_data_in,
  input wire logic config_update,
  output logic scan_data_out,
  output logic reconfig_done,
  // Resets to the channel blocks and the PLL
  output xcvr_reset_pkg::blk_rst_s blk_rst,
  output logic pll_rst_out
);
  xcvr_reset_pkg::pins_s pins_in; // Raw pin bundle
  xcvr_reset_pkg::pins_s sync1_reg; // First synchroniser stage, read only by stage two
  xcvr_reset_pkg::pins_s sync2_reg; // Second stage, safe to use
  logic scan_clk_d_reg; // Delayed scan clock for edge finding
  logic upd_d_reg; // Delayed update strobe
  logic scan_edge; // Enabled rising scan clock edge
  logic upd_edge; // Rising edge of the update strobe
  logic [`XR_CFG_BITS-1:0] shift_reg; // Scan chain
  logic [`XR_CFG_BITS-1:0] cfg_reg; // Settings the PLL runs with
  logic [2:0] ctrl_reg; // Software forced power-down and resets
  logic eff_pd; // Power-down from pin or software
  logic eff_rxpcs; // Receive PCS reset from pin or software
  logic eff_txpcs; // Transmit PCS reset from pin or software
  logic wr_fire; // Write address and data both taken
  logic rd_fire; // Read address taken

  assign pins_in = '{rx_pcs: rx_pcs_reset, rx_ana: rx_analog_reset, tx_pcs: tx_pcs_reset,
    pll: pll_reset, pd: chan_powerdown, scan_clk: scan_clk, scan_gate: scan_clk_gate,
    scan_din: scan_data_in, cfg_update: config_update};

  // Two-stage synchroniser on every fabric pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Edge history taken from the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_clk_d_reg <= 1'b0;
      upd_d_reg <= 1'b0;
    end else begin
      scan_clk_d_reg <= sync2_reg.scan_clk;
      upd_d_reg <= sync2_reg.cfg_update;
    end
  end

  // Gate and data travel the same synchroniser depth as the clock, so they line up
  assign scan_edge = sync2_reg.scan_clk & ~scan_clk_d_reg & sync2_reg.scan_gate;
  assign upd_edge = sync2_reg.cfg_update & ~upd_d_reg;

  assign eff_pd = sync2_reg.pd | ctrl_reg[`XR_CTRL_PD_BIT];
  assign eff_rxpcs = sync2_reg.rx_pcs | ctrl_reg[`XR_CTRL_RXPCS_BIT];
  assign eff_txpcs = sync2_reg.tx_pcs | ctrl_reg[`XR_CTRL_TXPCS_BIT];

  // Reset fan-out, registered so every output comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_rst <= '1;
      pll_rst_out <= 1'b1;
    end else begin
      blk_rst.rx_aligner <= eff_rxpcs | eff_pd;
      blk_rst.rx_deskew <= eff_rxpcs | eff_pd;
      blk_rst.rx_rate_fifo <= eff_rxpcs | eff_pd;
      blk_rst.rx_dec <= eff_rxpcs | eff_pd;
      blk_rst.rx_byte_deser <= eff_rxpcs | eff_pd;
      blk_rst.rx_byte_order <= eff_rxpcs | eff_pd;
      blk_rst.rx_phase_fifo <= eff_rxpcs | eff_pd;
      blk_rst.rx_xaui_sm <= eff_rxpcs | eff_pd;
      blk_rst.bist_ver <= eff_rxpcs | eff_pd;
      blk_rst.tx_ser <= eff_txpcs | eff_pd;
      blk_rst.tx_xaui_sm <= eff_txpcs | eff_pd;
      // Transmit buffer ignores the PCS reset and sees power-down only
      blk_rst.tx_buf <= eff_pd;
      blk_rst.rx_buf <= eff_pd;
      blk_rst.rx_deser <= eff_pd;
      blk_rst.rx_cdr <= sync2_reg.rx_ana | eff_pd;
      // The PLL reset is passed straight from the fabric; the controller owns its timing
      pll_rst_out <= sync2_reg.pll;
    end
  end

  // Scan chain: one bit in per enabled edge, oldest bit out at the top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg <= '0;
      scan_data_out <= 1'b0;
    end else begin
      if (scan_edge) begin
        shift_reg <= {shift_reg[`XR_CFG_BITS-2:0], sync2_reg.scan_din};
        scan_data_out <= shift_reg[`XR_CFG_BITS-2];
      end
    end
  end

  // Apply the chain on the update strobe and flag completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= '0;
      reconfig_done <= 1'b0;
    end else begin
      if (upd_edge) begin
        cfg_reg <= shift_reg;
      end
      // Setting wins over the clear by the PLL reset or a new shift
      if (upd_edge) begin
        reconfig_done <= 1'b1;
      end else if (sync2_reg.pll | scan_edge) begin
        reconfig_done <= 1'b0;
      end
    end
  end

  // AXI4-Lite write: both channels taken together in one cycle, response follows
  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `XR_RESP_OKAY;
      ctrl_reg <= `XR_CTRL_RST;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready <= wr_fire;
      if (wr_fire) begin
        // Status and configuration are read only; writes there are refused
        s_axi_bresp <= (s_axi_awaddr == `XR_CTRL_OFF) ? `XR_RESP_OKAY : `XR_RESP_SLVERR;
        if (s_axi_awaddr == `XR_CTRL_OFF && s_axi_wstrb[0]) begin
          ctrl_reg <= s_axi_wdata[2:0];
        end
      end
      // Response only once both handshakes are done, so it never overtakes them
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: address taken, data one cycle later
  assign rd_fire = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `XR_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rresp <= `XR_RESP_OKAY;
        case (s_axi_araddr)
          `XR_CTRL_OFF: s_axi_rdata <= {29'h0, ctrl_reg};
          `XR_STATUS_OFF: s_axi_rdata <= {14'h0, pll_rst_out, reconfig_done, 1'b0, blk_rst};
          `XR_CFG_OFF: s_axi_rdata <= {14'h0, cfg_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `XR_RESP_SLVERR;
          end
        endcase
      end
      // Data is offered only after the address handshake has completed
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks on the reset fan-out and the scan port
  rx_pcs_fan_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sync2_reg.rx_pcs |=> blk_rst.rx_aligner && blk_rst.bist_ver && blk_rst.rx_phase_fifo)
    else $error("receive PCS reset did not reach receive blocks");
  tx_pcs_fan_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sync2_reg.tx_pcs && !eff_pd && !sync2_reg.rx_ana && !eff_rxpcs) |=>
    blk_rst.tx_ser && !blk_rst.tx_buf && !blk_rst.rx_cdr && !blk_rst.rx_aligner)
    else $error("transmit PCS reset fan-out wrong");
  pd_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sync2_reg.pd |=> &blk_rst)
    else $error("power-down missed a block");
  cdr_analog_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sync2_reg.rx_ana && !eff_pd && !eff_rxpcs) |=> blk_rst.rx_cdr && !blk_rst.rx_aligner)
    else $error("analog reset fan-out wrong");
  done_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sync2_reg.cfg_update) |=> reconfig_done)
    else $error("done not raised one cycle after update");
  scan_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    scan_edge |=> scan_data_out == shift_reg[`XR_CFG_BITS-1])
    else $error("scan out not top of chain");
  gate_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !sync2_reg.scan_gate |=> $stable(shift_reg))
    else $error("chain moved while gate low");
  cfg_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !upd_edge |=> $stable(cfg_reg))
    else $error("configuration changed without update");
  shift_cv: cover property (@(posedge aclk) disable iff (!aresetn) scan_edge ##[1:40] upd_edge);
  pd_cv: cover property (@(posedge aclk) disable iff (!aresetn) $rose(sync2_reg.pd));
  wr_cv: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire ##2 s_axi_bvalid);
endmodule : xcvr_reset_pll_reconfig_port

// ===== tb/fabric_ctrl_model.sv
// Fabric reset logic and PLL reprogramming controller model
module fabric_ctrl_model (
  input wire logic aclk,
  input wire logic user_pll,
  input wire logic reconfig_done,
  output logic scan_clk,
  output logic scan_clk_gate,
  output logic scan_data_in,
  output logic config_update,
  output logic pll_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic auto_rst; // Controller reset, one edge behind done
  // One unbonded channel in a generic mode: no XAUI, so no bonding is needed
  // No PCIe mode either, so the generic reset ordering is the one that applies
  // One controller per PLL port, so one set of scan pins here
  initial begin
    scan_clk = 1'b0;
    scan_clk_gate = 1'b0;
    scan_data_in = 1'b0;
    config_update = 1'b0;
  end
  // Reset the PLL on the first edge that sees done high
  always @(posedge aclk) begin
    auto_rst <= (reconfig_done === 1'b1);
  end
  // Sequence reset from the user shares the same pin
  assign pll_reset = user_pll | auto_rst;
  // Frame: msb first, data settled half a period around each rise
  task automatic run(input logic [17:0] b);
    for (int i = 17; i >= 0; i--) begin
      scan_data_in = b[i];
      scan_clk_gate = 1'b1;
      #24 scan_clk = 1'b1;
      #24 scan_clk = 1'b0;
    end
    scan_clk_gate = 1'b0;
    // Released line flips so a stale bit cannot look valid
    scan_data_in = ~scan_data_in;
    #24 config_update = 1'b1;
    #24 config_update = 1'b0;
  endtask : run
endmodule : fabric_ctrl_model

// ===== tb/tb_top.sv
// Self-checking bench for the transceiver reset and PLL reprogramming block
`include "xcvr_reset_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, got;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic rx_pcs_reset, rx_analog_reset, tx_pcs_reset, pll_reset, chan_powerdown, user_pll, seen;
  logic scan_clk, scan_clk_gate, scan_data_in, config_update, scan_data_out, reconfig_done, pll_rst_out;
  xcvr_reset_pkg::blk_rst_s blk_rst; // Per-block reset lines
  int fail_count, samples_checked, cyc, seed, n;
  xcvr_reset_pll_reconfig_port xcvr_reset_pll_reconfig_port_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_pcs_reset(rx_pcs_reset), .rx_analog_reset(rx_analog_reset), .tx_pcs_reset(tx_pcs_reset),
    .pll_reset(pll_reset), .chan_powerdown(chan_powerdown),
    .scan_clk(scan_clk), .scan_clk_gate(scan_clk_gate), .scan_data_in(scan_data_in),
    .config_update(config_update), .scan_data_out(scan_data_out), .reconfig_done(reconfig_done),
    .blk_rst(blk_rst), .pll_rst_out(pll_rst_out)
  );
  fabric_ctrl_model fab_i (
    .aclk(aclk), .user_pll(user_pll), .reconfig_done(reconfig_done), .scan_clk(scan_clk),
    .scan_clk_gate(scan_clk_gate), .scan_data_in(scan_data_in), .config_update(config_update),
    .pll_reset(pll_reset)
  );
  // Model: v[4:0] pins, v[7:5] forcing bits of the control word
  function automatic logic [14:0] exp_rst(input logic [7:0] x);
    exp_rst = ((x[3] | x[5]) ? 15'h7fff : 15'h0000) | ((x[0] | x[6]) ? 15'h7fc0 : 15'h0000);
    exp_rst = exp_rst | ((x[2] | x[7]) ? 15'h0005 : 15'h0000) | (x[1] ? 15'h0010 : 15'h0000);
  endfunction : exp_rst
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // Write: address and data offered together, each dropped when taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Let an edge pass so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // Let an edge pass so a following call never reassigns rready in this step
    @(posedge aclk);
  endtask : axr
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    seed = 32'hcb98;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h000_000_00000000_f;
    {user_pll, chan_powerdown, tx_pcs_reset, rx_analog_reset, rx_pcs_reset} = 5'h00;
    repeat (6) @(posedge aclk);
    chk("blk_rst in reset", 32'h7fff, {17'h0, blk_rst});
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("blk_rst after reset", 32'h0, {17'h0, blk_rst});
    // Random pin and control mixes against the fan-out model
    for (int k = 0; k < 16; k++) begin
      v = $random(seed);
      {user_pll, chan_powerdown, tx_pcs_reset, rx_analog_reset, rx_pcs_reset} <= v[4:0];
      axw(`XR_CTRL_OFF, {29'h0, v[7:5]}, rsp);
      chk("ctrl bresp", {30'h0, `XR_RESP_OKAY}, {30'h0, rsp});
      repeat (4) @(posedge aclk);
      chk("blk_rst", {17'h0, exp_rst(v[7:0])}, {17'h0, blk_rst});
      chk("pll_rst_out", {31'h0, v[4]}, {31'h0, pll_rst_out});
      axr(`XR_CTRL_OFF, got, rsp);
      chk("ctrl", {29'h0, v[7:5]}, got);
      axr(`XR_STATUS_OFF, got, rsp);
      chk("status", {14'h0, v[4], 2'h0, exp_rst(v[7:0])}, got);
    end
    // Refused accesses: read-only and unmapped places
    {user_pll, chan_powerdown, tx_pcs_reset, rx_analog_reset, rx_pcs_reset} <= 5'h00;
    axw(`XR_CTRL_OFF, 32'h0, rsp);
    // Low byte masked off: accepted but the control word must not move
    s_axi_wstrb <= 4'he;
    axw(`XR_CTRL_OFF, 32'h7, rsp);
    chk("masked bresp", {30'h0, `XR_RESP_OKAY}, {30'h0, rsp});
    s_axi_wstrb <= 4'hf;
    axr(`XR_CTRL_OFF, got, rsp);
    chk("masked ctrl", 32'h0, got);
    axw(`XR_STATUS_OFF, 32'hffff_ffff, rsp);
    chk("ro bresp", {30'h0, `XR_RESP_SLVERR}, {30'h0, rsp});
    axr(12'hffc, got, rsp);
    chk("unmapped rdata", 32'h0, got);
    chk("unmapped rresp", {30'h0, `XR_RESP_SLVERR}, {30'h0, rsp});
    // Two reprogramming frames, each followed by the automatic reset
    for (int k = 0; k < 2; k++) begin
      v = $random(seed);
      fork
        fab_i.run(v[17:0]);
      join_none
      n = 0;
      while (reconfig_done !== 1'b1 && n < 2000) begin
        @(posedge aclk);
        n++;
      end
      chk("reconfig_done", 32'h1, {31'h0, reconfig_done});
      chk("scan_data_out", {31'h0, v[17]}, {31'h0, scan_data_out});
      seen = 1'b0;
      repeat (8) begin
        @(posedge aclk);
        seen = seen | (pll_rst_out === 1'b1);
      end
      chk("pll reset after done", 32'h1, {31'h0, seen});
      axr(`XR_CFG_OFF, got, rsp);
      chk("cfg", {14'h0, v[17:0]}, got);
    end
    close_out();
  end
endmodule : tb_top
